// ### rssw_pkg.sv
// constants and state types for the remote station status word block
// Operation
// R1: bit refresh areas 16..512 points in 16-point steps, word areas 1..32 words.
// R2: input areas together, and output areas together, at most 64 bytes each.
// R3: bit refresh area start number is a multiple of 16.
// R4: status word is 16 bits; only bits 7 and 15 mean anything.
// R5: status bit 7 follows the stop-class error, refreshed each operation cycle.
// R6: status bit 15 follows the continue-class error, refreshed each operation cycle.
// R7: error flags clear on error reset command or station power-up.
// R8: monitor area is ten words; words 4 to 9 read zero.
// R9: monitor word 0 holds station state 0..3, refreshed each operation cycle.
// R10: monitor word 1 captures the error code on stop or continue error.
// R11: monitor word 1 clears on error reset or station power-up.
// R12: monitor word 2 totals communication retries.
// R13: monitor word 3 counts consecutive retries, zero after a good exchange.
// R14: command bit 7 clears error code and flags when the error allows it.
// R15: software holds the reset command until the error flag drops.
// R16: non-resettable errors ignore the reset command, code and flags kept.
// R17: command word is 16 bits, bit 7 sampled once per main cycle.
// R18: all monitor words and flags reset to zero; unusable bits read zero.
package rssw_pkg;
	// register word offsets
	localparam logic [7:0] RSSW_OFF_RUN_STATE  = 8'h00;
	localparam logic [7:0] RSSW_OFF_ERR_CODE   = 8'h01;
	localparam logic [7:0] RSSW_OFF_RETRY_TOT  = 8'h02;
	localparam logic [7:0] RSSW_OFF_RETRY_CON  = 8'h03;
	localparam logic [7:0] RSSW_OFF_MON_LAST   = 8'h09;
	localparam logic [7:0] RSSW_OFF_ERR_FLAGS  = 8'h10;
	localparam logic [7:0] RSSW_OFF_CMD        = 8'h11;
	localparam logic [7:0] RSSW_OFF_IRQ_STAT   = 8'h12;
	localparam logic [7:0] RSSW_OFF_IRQ_MASK   = 8'h13;
	localparam logic [7:0] RSSW_OFF_IN_BITS    = 8'h14;
	localparam logic [7:0] RSSW_OFF_IN_WORDS   = 8'h15;
	localparam logic [7:0] RSSW_OFF_OUT_BITS   = 8'h16;
	localparam logic [7:0] RSSW_OFF_OUT_WORDS  = 8'h17;
	localparam logic [7:0] RSSW_OFF_IN_START   = 8'h18;
	localparam logic [7:0] RSSW_OFF_OUT_START  = 8'h19;
	localparam logic [7:0] RSSW_OFF_CFG_STAT   = 8'h1a;
	// field positions
	localparam int RSSW_BIT_STOP_ERR  = 7;
	localparam int RSSW_BIT_CONT_ERR  = 15;
	localparam int RSSW_BIT_ERR_RESET = 7;
	localparam int RSSW_IRQ_STOP      = 0;
	localparam int RSSW_IRQ_CONT      = 1;
	localparam int RSSW_IRQ_RETRY     = 2;
	localparam int RSSW_IRQ_CFG       = 3;
	localparam int RSSW_IRQ_W         = 4;
	// sizing limits of the refresh areas
	localparam logic [15:0] RSSW_BIT_MIN   = 16'h0010;
	localparam logic [15:0] RSSW_BIT_MAX   = 16'h0200;
	localparam logic [15:0] RSSW_WORD_MIN  = 16'h0001;
	localparam logic [15:0] RSSW_WORD_MAX  = 16'h0020;
	localparam logic [15:0] RSSW_BYTE_MAX  = 16'h0040;
	localparam logic [15:0] RSSW_ALIGN_MSK = 16'h000f;
	// reset values
	localparam logic [15:0] RSSW_RST_WORD  = 16'h0000;
	localparam logic [15:0] RSSW_RST_BITS  = 16'h0010;
	localparam logic [15:0] RSSW_RST_WORDS = 16'h0001;
	// station states reported on monitor word 0
	localparam logic [1:0] RSSW_ST_NOCOMM = 2'h0;
	localparam logic [1:0] RSSW_ST_STOP   = 2'h1;
	localparam logic [1:0] RSSW_ST_RUN    = 2'h2;
	localparam logic [1:0] RSSW_ST_ERROR  = 2'h3;

	// error-reset handshake phase
	typedef enum logic [2:0] {
		RSSW_RS_IDLE = 3'b001,
		RSSW_RS_HELD = 3'b010,
		RSSW_RS_DONE = 3'b100
	} rssw_rs_t;

	typedef struct packed {
		logic [1:0]          run_state;
		logic [15:0]         err_code;
		logic [15:0]         retry_tot;
		logic [15:0]         retry_con;
		logic                stop_err;
		logic                cont_err;
		logic [15:0]         cmd;
		logic                rst_req;
		rssw_rs_t            rs;
		logic [RSSW_IRQ_W-1:0] irq_stat;
		logic [RSSW_IRQ_W-1:0] irq_mask;
		logic [15:0]         in_bits;
		logic [15:0]         in_words;
		logic [15:0]         out_bits;
		logic [15:0]         out_words;
		logic [15:0]         in_start;
		logic [15:0]         out_start;
		logic [2:0]          cfg_err;
		logic                cfg_any;
		logic [15:0]         rdata;
		logic                irq;
	} rssw_state_t;
endpackage : rssw_pkg

// ### rssw_top.sv
// status, monitor and command words for one remote station
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module rssw_top
	import rssw_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	// controller cycle ticks
	input  wire logic        i_op_tick,
	input  wire logic        i_main_tick,
	// station report
	input  wire logic [1:0]  i_station_state,
	input  wire logic        i_stop_err,
	input  wire logic        i_cont_err,
	input  wire logic [15:0] i_err_code,
	input  wire logic        i_err_resettable,
	input  wire logic        i_station_powerup,
	input  wire logic        i_retry,
	input  wire logic        i_xfer_ok,
	// register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	// station side outputs
	output logic             o_err_reset,
	output logic             o_stop_err,
	output logic             o_cont_err,
	output logic             o_cfg_err,
	output logic             o_irq
);

	rssw_state_t s_reg;
	rssw_state_t s_next;

	logic [15:0] flags_word;
	logic [15:0] in_bytes;
	logic [15:0] out_bytes;
	logic        cfg_bad_size;
	logic        cfg_bad_sum;
	logic        cfg_bad_align;
	logic        err_any;
	logic        do_reset;
	logic [RSSW_IRQ_W-1:0] ev;
	logic [RSSW_IRQ_W-1:0] w1c;

	// status word: only the two error flags, the rest reads zero
	always_comb begin
		flags_word = RSSW_RST_WORD;
		flags_word[RSSW_BIT_STOP_ERR] = s_reg.stop_err;  // [R4] [R5]
		flags_word[RSSW_BIT_CONT_ERR] = s_reg.cont_err;  // [R4] [R6]
	end

	// area sizing checks; a bad setting is reported, not corrected
	assign in_bytes  = (s_reg.in_bits >> 3) + (s_reg.in_words << 1);
	assign out_bytes = (s_reg.out_bits >> 3) + (s_reg.out_words << 1);
	assign cfg_bad_size =
		(s_reg.in_bits < RSSW_BIT_MIN) || (s_reg.in_bits > RSSW_BIT_MAX) ||
		((s_reg.in_bits & RSSW_ALIGN_MSK) != 16'h0000) ||
		(s_reg.out_bits < RSSW_BIT_MIN) || (s_reg.out_bits > RSSW_BIT_MAX) ||
		((s_reg.out_bits & RSSW_ALIGN_MSK) != 16'h0000) ||
		(s_reg.in_words < RSSW_WORD_MIN) || (s_reg.in_words > RSSW_WORD_MAX) ||
		(s_reg.out_words < RSSW_WORD_MIN) || (s_reg.out_words > RSSW_WORD_MAX); // [R1]
	assign cfg_bad_sum = (in_bytes > RSSW_BYTE_MAX) || (out_bytes > RSSW_BYTE_MAX); // [R2]
	assign cfg_bad_align = ((s_reg.in_start & RSSW_ALIGN_MSK) != 16'h0000) ||
		((s_reg.out_start & RSSW_ALIGN_MSK) != 16'h0000); // [R3]

	assign err_any = s_reg.stop_err || s_reg.cont_err;

	// reset is taken only on a main cycle, and only if the station allows it
	assign do_reset = i_main_tick && s_reg.cmd[RSSW_BIT_ERR_RESET] &&
		i_err_resettable; // [R14] [R16] [R17]

	// write-one-to-clear mask for the interrupt status
	assign w1c = (i_wr && (i_addr == RSSW_OFF_IRQ_STAT)) ?
		i_wdata[RSSW_IRQ_W-1:0] : {RSSW_IRQ_W{1'b0}};

	// next state
	always_comb begin
		s_next = s_reg;
		ev = {RSSW_IRQ_W{1'b0}};

		// station state word refreshed each operation cycle
		if (i_op_tick) begin
			s_next.run_state = i_station_state; // [R9]
		end

		// error flags: clear first, a fresh report in the same cycle wins over the reset command but not over power-up
		if (do_reset || i_station_powerup) begin
			s_next.stop_err = 1'b0;  // [R7] [R14]
			s_next.cont_err = 1'b0;  // [R7] [R14]
			s_next.err_code = RSSW_RST_WORD; // [R11]
		end
		if (i_op_tick && i_stop_err && !i_station_powerup) begin
			s_next.stop_err = 1'b1;  // [R5]
			s_next.err_code = i_err_code; // [R10]
			ev[RSSW_IRQ_STOP] = !s_reg.stop_err;
		end
		if (i_op_tick && i_cont_err && !i_station_powerup) begin
			s_next.cont_err = 1'b1;  // [R6]
			if (!i_stop_err) begin
				s_next.err_code = i_err_code; // [R10]
			end
			ev[RSSW_IRQ_CONT] = !s_reg.cont_err;
		end

		// retry counters saturate rather than wrap
		if (i_retry) begin
			if (s_reg.retry_tot != 16'hffff) begin
				s_next.retry_tot = s_reg.retry_tot + 16'h0001; // [R12]
			end
			if (s_reg.retry_con != 16'hffff) begin
				s_next.retry_con = s_reg.retry_con + 16'h0001; // [R13]
			end
			ev[RSSW_IRQ_RETRY] = 1'b1;
		end else if (i_xfer_ok) begin
			s_next.retry_con = RSSW_RST_WORD; // [R13]
		end

		// sizing check result, event when a fault appears while none was set
		s_next.cfg_err = {cfg_bad_align, cfg_bad_sum, cfg_bad_size};
		// kept as its own flop so the fault pin needs no gate after the register
		s_next.cfg_any = cfg_bad_align || cfg_bad_sum || cfg_bad_size; // [R1] [R2] [R3]
		ev[RSSW_IRQ_CFG] = (s_next.cfg_err != 3'h0) && (s_reg.cfg_err == 3'h0);

		// reset handshake phase, software releases the command after the flags drop
		unique case (s_reg.rs)
			RSSW_RS_IDLE: begin
				if (s_reg.cmd[RSSW_BIT_ERR_RESET]) begin
					s_next.rs = RSSW_RS_HELD;
				end
			end
			RSSW_RS_HELD: begin
				if (!s_reg.cmd[RSSW_BIT_ERR_RESET]) begin
					s_next.rs = RSSW_RS_IDLE;
				end else if (!err_any) begin
					s_next.rs = RSSW_RS_DONE; // [R15]
				end
			end
			RSSW_RS_DONE: begin
				if (!s_reg.cmd[RSSW_BIT_ERR_RESET]) begin
					s_next.rs = RSSW_RS_IDLE;
				end
			end
			default: begin
				s_next.rs = RSSW_RS_IDLE;
			end
		endcase
		if (i_main_tick) begin
			s_next.rst_req = s_reg.cmd[RSSW_BIT_ERR_RESET]; // [R17]
		end

		// register writes; only bit 7 of the command word is kept
		if (i_wr) begin
			unique case (i_addr)
				RSSW_OFF_CMD: begin
					s_next.cmd = RSSW_RST_WORD;
					s_next.cmd[RSSW_BIT_ERR_RESET] = i_wdata[RSSW_BIT_ERR_RESET]; // [R17]
				end
				RSSW_OFF_IRQ_MASK: s_next.irq_mask  = i_wdata[RSSW_IRQ_W-1:0];
				RSSW_OFF_IN_BITS:  s_next.in_bits   = i_wdata;
				RSSW_OFF_IN_WORDS: s_next.in_words  = i_wdata;
				RSSW_OFF_OUT_BITS: s_next.out_bits  = i_wdata;
				RSSW_OFF_OUT_WORDS: s_next.out_words = i_wdata;
				RSSW_OFF_IN_START: s_next.in_start  = i_wdata;
				RSSW_OFF_OUT_START: s_next.out_start = i_wdata;
				default: begin
				end
			endcase
		end

		// sticky interrupt status, a new event beats a clear
		s_next.irq_stat = (s_reg.irq_stat & ~w1c) | ev;
		s_next.irq = |(s_next.irq_stat & s_next.irq_mask);

		// read data one cycle after the strobe; unusable words read zero
		s_next.rdata = RSSW_RST_WORD;
		if (i_rd) begin
			unique case (i_addr)
				RSSW_OFF_RUN_STATE:  s_next.rdata = {14'h0000, s_reg.run_state}; // [R9]
				RSSW_OFF_ERR_CODE:   s_next.rdata = s_reg.err_code;
				RSSW_OFF_RETRY_TOT:  s_next.rdata = s_reg.retry_tot;
				RSSW_OFF_RETRY_CON:  s_next.rdata = s_reg.retry_con;
				RSSW_OFF_ERR_FLAGS:  s_next.rdata = flags_word;
				RSSW_OFF_CMD:        s_next.rdata = s_reg.cmd;
				RSSW_OFF_IRQ_STAT:   s_next.rdata = {12'h000, s_reg.irq_stat};
				RSSW_OFF_IRQ_MASK:   s_next.rdata = {12'h000, s_reg.irq_mask};
				RSSW_OFF_IN_BITS:    s_next.rdata = s_reg.in_bits;
				RSSW_OFF_IN_WORDS:   s_next.rdata = s_reg.in_words;
				RSSW_OFF_OUT_BITS:   s_next.rdata = s_reg.out_bits;
				RSSW_OFF_OUT_WORDS:  s_next.rdata = s_reg.out_words;
				RSSW_OFF_IN_START:   s_next.rdata = s_reg.in_start;
				RSSW_OFF_OUT_START:  s_next.rdata = s_reg.out_start;
				RSSW_OFF_CFG_STAT:   s_next.rdata = {13'h0000, s_reg.cfg_err};
				default:             s_next.rdata = RSSW_RST_WORD; // [R8] [R18]
			endcase
		end
	end

	// state register; everything software sees starts at zero except the area sizes, which start at 16 points and 1 word
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			s_reg.run_state <= RSSW_ST_NOCOMM; // [R18]
			s_reg.err_code  <= RSSW_RST_WORD;  // [R18]
			s_reg.retry_tot <= RSSW_RST_WORD;  // [R18]
			s_reg.retry_con <= RSSW_RST_WORD;  // [R18]
			s_reg.stop_err  <= 1'b0;
			s_reg.cont_err  <= 1'b0;
			s_reg.cmd       <= RSSW_RST_WORD;
			s_reg.rst_req   <= 1'b0;
			s_reg.rs        <= RSSW_RS_IDLE;
			s_reg.irq_stat  <= {RSSW_IRQ_W{1'b0}};
			s_reg.irq_mask  <= {RSSW_IRQ_W{1'b0}};
			s_reg.in_bits   <= RSSW_RST_BITS;
			s_reg.in_words  <= RSSW_RST_WORDS;
			s_reg.out_bits  <= RSSW_RST_BITS;
			s_reg.out_words <= RSSW_RST_WORDS;
			s_reg.in_start  <= RSSW_RST_WORD;
			s_reg.out_start <= RSSW_RST_WORD;
			s_reg.cfg_err   <= 3'h0;
			s_reg.cfg_any   <= 1'b0;
			s_reg.rdata     <= RSSW_RST_WORD;
			s_reg.irq       <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from flops
	assign o_rdata     = s_reg.rdata;
	assign o_err_reset = s_reg.rst_req;
	assign o_stop_err  = s_reg.stop_err;
	assign o_cont_err  = s_reg.cont_err;
	assign o_cfg_err   = s_reg.cfg_any;
	assign o_irq       = s_reg.irq;

endmodule : rssw_top

// ### rssw_chk.sv
// assertion checker for the remote station status word ports
`timescale 1ns/100ps
module rssw_chk
	import rssw_pkg::*;
(
	// clock, reset and ticks
	input wire logic        i_ref_clk,
	input wire logic        i_rst,
	input wire logic        i_op_tick,
	input wire logic        i_main_tick,
	// station report
	input wire logic        i_stop_err,
	input wire logic        i_cont_err,
	input wire logic        i_err_resettable,
	input wire logic        i_station_powerup,
	// register port and flags
	input wire logic [7:0]  i_addr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic        o_err_reset,
	input wire logic        o_stop_err,
	input wire logic        o_cont_err
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	// a reported error reaches its flag one cycle after the tick
	AST_STOP_SET: assert property (i_op_tick && i_stop_err && !i_station_powerup |=> o_stop_err)
		else $error("stop flag missed");
	AST_CONT_SET: assert property (i_op_tick && i_cont_err && !i_station_powerup |=> o_cont_err)
		else $error("continue flag missed");
	// power-up wins over everything, so both flags drop
	AST_PWR_CLR: assert property (i_station_powerup |=> !o_stop_err && !o_cont_err)
		else $error("flags kept over power-up");
	// a fault that refuses reset keeps its flag
	AST_NORESET: assert property (!i_err_resettable && !i_station_powerup && o_stop_err |=> o_stop_err)
		else $error("flag lost without reset");
	AST_NORESET_C: assert property (!i_err_resettable && !i_station_powerup && o_cont_err |=> o_cont_err)
		else $error("continue flag lost without reset");
	// the command copy moves only on a main tick
	AST_CMD_MAIN: assert property (!i_main_tick |=> $stable(o_err_reset))
		else $error("command sampled off main tick");
	// read data is zero outside the cycle after a read
	AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000)
		else $error("read data outside read");
	AST_MON_ZERO: assert property (i_rd && i_addr inside {[8'h04:8'h09]} |=> o_rdata == 16'h0000)
		else $error("unusable monitor word not zero");
	AST_FLAG_RD:
	assert property (i_rd && i_addr == RSSW_OFF_ERR_FLAGS |=> o_rdata == {$past(o_cont_err), 7'h0, $past(o_stop_err), 7'h0})
		else $error("status word layout wrong");
endmodule : rssw_chk

bind rssw_top rssw_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_op_tick(i_op_tick),
	.i_main_tick(i_main_tick), .i_stop_err(i_stop_err), .i_cont_err(i_cont_err),
	.i_err_resettable(i_err_resettable), .i_station_powerup(i_station_powerup), .i_addr(i_addr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_err_reset(o_err_reset), .o_stop_err(o_stop_err), .o_cont_err(o_cont_err));

// ### rssw_station.sv
// behavioural remote station that raises and clears errors
`timescale 1ns/100ps
module rssw_station
	import rssw_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	// bench controls
	input  wire logic        i_make_stop,
	input  wire logic        i_make_cont,
	input  wire logic [15:0] i_code,
	input  wire logic        i_can_reset,
	input  wire logic        i_powerup,
	input  wire logic        i_err_reset,
	// station report
	output logic      [1:0]  o_state,
	output logic             o_stop_err,
	output logic             o_cont_err,
	output logic      [15:0] o_err_code
);
	// an error holds until a resettable command is seen or power returns
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || i_powerup || (i_err_reset && i_can_reset)) begin
			o_stop_err <= 1'b0;
			o_cont_err <= 1'b0;
		end else begin
			o_stop_err <= o_stop_err | i_make_stop;
			o_cont_err <= o_cont_err | i_make_cont;
		end
	end
	// code line means nothing without an error, so it shows the inverse then
	assign o_err_code = (o_stop_err | o_cont_err) ? i_code : ~i_code;
	assign o_state    = (o_stop_err | o_cont_err) ? RSSW_ST_ERROR : RSSW_ST_RUN;
endmodule : rssw_station

// ### rssw_tb_top.sv
// self-checking bench for the remote station status words
`timescale 1ns/100ps
module rssw_tb_top;
	import rssw_pkg::*;
	logic        i_ref_clk = 1'b0, i_rst = 1'b1, i_op_tick = 1'b0, i_main_tick = 1'b0;
	logic        i_wr = 1'b0, i_rd = 1'b0, i_err_resettable = 1'b0;
	logic [4:0]  pl = 5'h00; // cont, stop, powerup, good exchange, retry
	logic [7:0]  i_addr = 8'h00, cyc = 8'h00;
	logic [15:0] i_wdata = 16'h0000, f_code = 16'h0000, i_err_code, o_rdata;
	logic [1:0]  i_station_state;
	logic        i_stop_err, i_cont_err, o_err_reset, o_stop_err, o_cont_err, o_cfg_err, o_irq;
	int          err_count = 0, n_checks = 0;
	// address, data and expected sizing faults
	logic [27:0] ct [12] = '{28'h1400181, 28'h1400100, 28'h1402002, 28'h1400100, 28'h1500213, 28'h1500001,
		28'h1500010, 28'h1800084, 28'h1800000, 28'h17001f0, 28'h1600202, 28'h1600100};

	rssw_top u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_op_tick(i_op_tick), .i_main_tick(i_main_tick),
		.i_station_state(i_station_state), .i_stop_err(i_stop_err), .i_cont_err(i_cont_err),
		.i_err_code(i_err_code), .i_err_resettable(i_err_resettable), .i_station_powerup(pl[2]),
		.i_retry(pl[0]), .i_xfer_ok(pl[1]), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_err_reset(o_err_reset), .o_stop_err(o_stop_err), .o_cont_err(o_cont_err),
		.o_cfg_err(o_cfg_err), .o_irq(o_irq));
	rssw_station u_stn (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_make_stop(pl[3]), .i_make_cont(pl[4]),
		.i_code(f_code), .i_can_reset(i_err_resettable), .i_powerup(pl[2]), .i_err_reset(o_err_reset),
		.o_state(i_station_state), .o_stop_err(i_stop_err), .o_cont_err(i_cont_err), .o_err_code(i_err_code));

	always #25 i_ref_clk = ~i_ref_clk;
	// ticks kept apart so a clear never lands beside a refresh
	always @(posedge i_ref_clk) begin
		cyc         <= cyc + 8'h01;
		i_op_tick   <= (cyc[2:0] == 3'h7);
		i_main_tick <= (cyc[3:0] == 4'h3);
	end

	task print_verdict();
		$display("comparisons %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr
	// data stand only in the cycle after the strobe, so look mid-cycle there
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge i_ref_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		chk($sformatf("word %h", a), e, o_rdata);
	endtask : rd
	task pls(input logic [4:0] k);
		@(posedge i_ref_clk);
		pl <= k;
		@(posedge i_ref_clk);
		pl <= 5'h00;
	endtask : pls
	task idle(input int n);
		repeat (n) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
	endtask : idle
	// bounded wait for the flag pair; running out ends the run
	task wflags(input logic [1:0] e);
		int n;
		n = 0;
		@(negedge i_ref_clk);
		while ({o_cont_err, o_stop_err} !== e && n < 300) begin
			@(negedge i_ref_clk);
			n++;
		end
		chk("flags", {14'h0, e}, {14'h0, o_cont_err, o_stop_err});
		if (n == 300) begin
			print_verdict();
		end
	endtask : wflags
	function automatic logic [15:0] rv(input int a);
		case (a)
			0: rv = {14'h0, RSSW_ST_RUN};
			8'h14, 8'h16: rv = RSSW_RST_BITS;
			8'h15, 8'h17: rv = RSSW_RST_WORDS;
			default: rv = 16'h0000;
		endcase
	endfunction : rv

	initial begin
		repeat (4) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		idle(20);
		for (int a = 0; a < 28; a++) rd(a[7:0], rv(a));
		wr(8'h00, 16'hffff);
		rd(8'h00, 16'h0002);
		$display("test reset values done");
		@(posedge i_ref_clk);
		f_code           <= 16'h0055;
		i_err_resettable <= 1'b1;
		pls(5'h08);
		wflags(2'b01);
		rd(8'h10, 16'h0080);
		rd(8'h01, 16'h0055);
		rd(8'h00, 16'h0003);
		rd(8'h12, 16'h0001);
		wr(8'h13, 16'h0001);
		idle(3);
		chk("irq", 16'h0001, {15'h0, o_irq});
		wr(8'h12, 16'h0001);
		idle(3);
		chk("irq", 16'h0000, {15'h0, o_irq});
		wr(8'h11, 16'hff80);
		rd(8'h11, 16'h0080);
		wflags(2'b00);
		chk("err_reset", 16'h0001, {15'h0, o_err_reset});
		rd(8'h01, 16'h0000);
		wr(8'h11, 16'h0000);
		idle(20);
		chk("err_reset", 16'h0000, {15'h0, o_err_reset});
		$display("test stop error done");
		@(posedge i_ref_clk);
		f_code           <= 16'h1234;
		i_err_resettable <= 1'b0;
		pls(5'h10);
		wflags(2'b10);
		wr(8'h11, 16'h0080);
		idle(40);
		chk("kept flags", 16'h0002, {14'h0, o_cont_err, o_stop_err});
		rd(8'h01, 16'h1234);
		rd(8'h10, 16'h8000);
		pls(5'h04);
		wflags(2'b00);
		rd(8'h01, 16'h0000);
		wr(8'h11, 16'h0000);
		$display("test continue error done");
		for (int i = 0; i < 3; i++) pls(5'h01);
		rd(8'h02, 16'h0003);
		rd(8'h03, 16'h0003);
		pls(5'h02);
		rd(8'h03, 16'h0000);
		pls(5'h01);
		rd(8'h02, 16'h0004);
		rd(8'h03, 16'h0001);
		rd(8'h12, 16'h0006);
		$display("test retries done");
		for (int i = 0; i < 12; i++) begin
			wr(ct[i][27:20], ct[i][19:4]);
			rd(8'h1a, {12'h0, ct[i][3:0]});
			chk("cfg_err", {15'h0, ct[i][3:0] != 4'h0}, {15'h0, o_cfg_err});
		end
		rd(8'h12, 16'h000e);
		$display("test sizing done");
		print_verdict();
	end
endmodule : rssw_tb_top
